// File: core/ianl_pkg.sv
// Constants, types and register map of the interrupt acknowledge and nesting logic
//
// Summary of operation
// - Non-maskable requests ignore the enable flag and beat every maskable source; break beats them.
// - Non-maskable entry saves status then counter, clears both flags, takes its vector.
// - A non-maskable request during its own handler waits for return plus one instruction.
// - Several non-maskable requests during one handler collapse into one pending request.
// - A maskable source is eligible only with request flag 1 and mask flag 0.
// - Eligible maskable requests are taken only while the enable flag is 1.
// - While in-service flag is 0, low-level maskable requests are refused.
// - During non-maskable servicing nothing but break is taken, even after enable.
// - Maskable entry takes 7 to 32 clocks at high level, 8 to 33 low.
// - Among eligible requests the higher level wins, then the default order.
// - A refused request stays pending and is taken once conditions allow.
// - Maskable entry saves status then counter, clears enable, copies level to in-service.
// - Break always interrupts, saves status and counter, clears enable, vectors 003EH.
// - Every acceptance clears the enable flag; nesting needs an explicit enable.
// - With enable set, equal or higher level requests nest, lower ones wait.
// - A request held during servicing is taken after return plus one instruction.
// - Nesting follows the matrix of handler kind, in-service flag and level.
// - After status, enable, return or flag register instructions, acceptance waits one instruction.
// - Break does not defer acceptance, yet its cleared enable blocks maskable requests.
// - A source's level flag never affects how its request flag gets set.
// - Acceptance clears the accepted source's request flag before its handler starts.
// - Returns and status pops restore the whole status word, flags included.
// - Reset loads the status word with 02H: enable clear, in-service set.
package ianl_pkg;

	// ==========================================================
	// Sizes
	localparam int NSRC = 18;
	localparam int IDX_W = 5;
	localparam int DEPTH_W = 4;

	// ==========================================================
	// Register offsets
	localparam logic [11:0] OFS_REQ = 12'h000;
	localparam logic [11:0] OFS_MASK = 12'h004;
	localparam logic [11:0] OFS_PRIO = 12'h008;
	localparam logic [11:0] OFS_PSW = 12'h00c;
	localparam logic [11:0] OFS_STAT = 12'h010;

	// ==========================================================
	// Reset values and status word fields
	localparam logic [NSRC-1:0] REQ_RST = 18'h00000;
	localparam logic [NSRC-1:0] MASK_RST = 18'h3ffff;
	localparam logic [NSRC-1:0] PRIO_RST = 18'h3ffff;
	localparam logic [7:0] PSW_RST = 8'h02;
	localparam int PSW_ENABLE_BIT = 7;
	localparam int PSW_SERVICE_BIT = 1;

	// ==========================================================
	// Vectors
	localparam logic [15:0] VEC_SOFT = 16'h003e;
	localparam logic [15:0] VEC_NMI = 16'h0004;
	localparam logic [15:0] VEC_BASE = 16'h0006;

	// ==========================================================
	// Entry timing in CPU clocks, deferral counts in instruction boundaries
	localparam int LAT_MIN_HI_CLK = 7;
	localparam int LAT_MIN_LO_CLK = 8;
	localparam logic [3:0] ENTRY_HI = 4'(LAT_MIN_HI_CLK - 1);
	localparam logic [3:0] ENTRY_LO = 4'(LAT_MIN_LO_CLK - 1);
	localparam logic [1:0] DEFER_REG = 2'h2;
	localparam logic [1:0] DEFER_INS = 2'h1;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		INS_PLAIN, INS_HOLD, INS_EI, INS_DI, INS_PSW_LOAD, INS_RETURN_FROM_INTERRUPT_INSTR, INS_RETURN_FROM_BREAK_INSTR, INS_BRK
	} ianl_instr_type;

	typedef enum logic [1:0] {SRC_NMI, SRC_MASK, SRC_SOFT} ianl_src_type;

	typedef struct packed {
		logic done;
		ianl_instr_type kind;
		logic [7:0] processor_status_word;
	} ianl_seq_type;

	typedef struct packed {
		logic take;
		ianl_src_type src;
		logic [IDX_W-1:0] idx;
		logic [15:0] vector;
		logic [7:0] psw_save;
		logic stall;
	} ianl_ack_type;

endpackage : ianl_pkg

// File: core/ianl_core.sv
// Interrupt acknowledge, nesting and pending logic with an APB register port
`timescale 1ns/1ps
`default_nettype none

module ianl_core (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Instruction sequencer
	input wire ianl_pkg::ianl_seq_type seq_i,
	output ianl_pkg::ianl_ack_type ack_o,
	output logic [7:0] psw_o,
	// Interrupt sources
	input wire logic [ianl_pkg::NSRC-1:0] src_event,
	input wire logic nmi_event
);

	// ==========================================================
	// State
	logic [ianl_pkg::NSRC-1:0] req_q;
	logic [ianl_pkg::NSRC-1:0] mask_q;
	logic [ianl_pkg::NSRC-1:0] prio_q;
	logic [7:0] psw_q;
	logic nmi_pend_q;
	logic nmi_active_q;
	logic [ianl_pkg::DEPTH_W-1:0] brk_depth_q;
	logic [1:0] defer_q;
	logic [3:0] stall_cnt_q;
	ianl_pkg::ianl_ack_type ack_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	// ==========================================================
	// Decode of bus and instruction boundary
	logic apb_setup;
	logic apb_wr;
	logic wr_req;
	logic wr_mask;
	logic wr_prio;
	logic wr_psw;
	logic boundary;
	logic hold_ins;
	logic accept_ok;

	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite && pready_q;
	assign wr_req = apb_wr && (paddr == ianl_pkg::OFS_REQ);
	assign wr_mask = apb_wr && (paddr == ianl_pkg::OFS_MASK);
	assign wr_prio = apb_wr && (paddr == ianl_pkg::OFS_PRIO);
	assign wr_psw = apb_wr && (paddr == ianl_pkg::OFS_PSW);

	// Sequencer stays quiet during entry; boundaries there are ignored
	assign boundary = seq_i.done && (stall_cnt_q == 4'h0);

	// Instructions after which acceptance waits one more instruction
	always_comb begin
		case (seq_i.kind)
			ianl_pkg::INS_HOLD, ianl_pkg::INS_EI, ianl_pkg::INS_DI,
			ianl_pkg::INS_PSW_LOAD, ianl_pkg::INS_RETURN_FROM_INTERRUPT_INSTR, ianl_pkg::INS_RETURN_FROM_BREAK_INSTR: begin
				hold_ins = 1'b1;
			end
			default: begin
				hold_ins = 1'b0;
			end
		endcase
	end

	// No acceptance at a hold boundary or while a deferral runs
	assign accept_ok = boundary && !hold_ins && (defer_q == 2'h0)
		&& !wr_req && !wr_mask && !wr_prio && !wr_psw;

	// ==========================================================
	// Eligibility per source
	logic [ianl_pkg::NSRC-1:0] elig;
	logic [ianl_pkg::NSRC-1:0] allowed;
	logic accept_enable_flag;
	logic in_service_priority_flag;

	assign accept_enable_flag = psw_q[ianl_pkg::PSW_ENABLE_BIT];
	assign in_service_priority_flag = psw_q[ianl_pkg::PSW_SERVICE_BIT];

	genvar g;
	generate
		for (g = 0; g < ianl_pkg::NSRC; g++) begin : g_elig
			// Request set and mask clear
			assign elig[g] = req_q[g] && !mask_q[g];
			// Low level refused while a high-level handler runs
			assign allowed[g] = elig[g] && (!prio_q[g] || in_service_priority_flag);
		end
	endgenerate

	// ==========================================================
	// Arbitration: high level first, then lowest index
	function automatic logic [ianl_pkg::IDX_W:0] pick_first(
		input logic [ianl_pkg::NSRC-1:0] v
	);
		logic [ianl_pkg::IDX_W:0] r;
		r = '0;
		for (int i = ianl_pkg::NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, ianl_pkg::IDX_W'(i)};
			end
		end
		return r;
	endfunction : pick_first

	logic [ianl_pkg::IDX_W:0] pick_hi;
	logic [ianl_pkg::IDX_W:0] pick_lo;
	logic win_any;
	logic [ianl_pkg::IDX_W-1:0] win_idx;
	logic win_lvl;

	assign pick_hi = pick_first(allowed & ~prio_q);
	assign pick_lo = pick_first(allowed & prio_q);

	// Programmed level beats default order
	always_comb begin
		if (pick_hi[ianl_pkg::IDX_W]) begin
			win_any = 1'b1;
			win_idx = pick_hi[ianl_pkg::IDX_W-1:0];
			win_lvl = 1'b0;
		end else if (pick_lo[ianl_pkg::IDX_W]) begin
			win_any = 1'b1;
			win_idx = pick_lo[ianl_pkg::IDX_W-1:0];
			win_lvl = 1'b1;
		end else begin
			win_any = 1'b0;
			win_idx = '0;
			win_lvl = 1'b0;
		end
	end

	// ==========================================================
	// Acceptance decisions
	logic take_soft;
	logic take_nmi;
	logic take_mask;
	logic take_any;

	// Break needs no enable and is never deferred
	assign take_soft = boundary && (seq_i.kind == ianl_pkg::INS_BRK);
	// Non-maskable ignores enable and level, waits out its own handler
	assign take_nmi = accept_ok && !take_soft && nmi_pend_q && !nmi_active_q;
	// Maskable needs enable, no non-maskable handler, no non-maskable winner
	assign take_mask = accept_ok && !take_soft && !take_nmi && win_any && accept_enable_flag
		&& !nmi_active_q;
	assign take_any = take_soft || take_nmi || take_mask;

	// ==========================================================
	// Request flags: event set wins over clear and bus write
	logic [ianl_pkg::NSRC-1:0] req_d;

	generate
		for (g = 0; g < ianl_pkg::NSRC; g++) begin : g_req
			always_comb begin
				req_d[g] = wr_req ? pwdata[g] : req_q[g];
				if (take_mask && (win_idx == ianl_pkg::IDX_W'(g))) begin
					req_d[g] = 1'b0;
				end
				if (src_event[g]) begin
					req_d[g] = 1'b1;
				end
			end
		end
	endgenerate

	// Request flag register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_q <= ianl_pkg::REQ_RST;
		end else begin
			req_q <= req_d;
		end
	end

	// Mask and level registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= ianl_pkg::MASK_RST;
			prio_q <= ianl_pkg::PRIO_RST;
		end else begin
			if (wr_mask) begin
				mask_q <= pwdata[ianl_pkg::NSRC-1:0];
			end
			if (wr_prio) begin
				prio_q <= pwdata[ianl_pkg::NSRC-1:0];
			end
		end
	end

	// ==========================================================
	// Status word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psw_q <= ianl_pkg::PSW_RST;
		end else if (take_any) begin
			psw_q[ianl_pkg::PSW_ENABLE_BIT] <= 1'b0;
			if (take_nmi) begin
				psw_q[ianl_pkg::PSW_SERVICE_BIT] <= 1'b0;
			end else if (take_mask) begin
				psw_q[ianl_pkg::PSW_SERVICE_BIT] <= win_lvl;
			end
		end else if (wr_psw) begin
			psw_q <= pwdata[7:0];
		end else if (boundary) begin
			case (seq_i.kind)
				ianl_pkg::INS_EI: begin
					psw_q[ianl_pkg::PSW_ENABLE_BIT] <= 1'b1;
				end
				ianl_pkg::INS_DI: begin
					psw_q[ianl_pkg::PSW_ENABLE_BIT] <= 1'b0;
				end
				ianl_pkg::INS_PSW_LOAD, ianl_pkg::INS_RETURN_FROM_INTERRUPT_INSTR, ianl_pkg::INS_RETURN_FROM_BREAK_INSTR: begin
					psw_q <= seq_i.processor_status_word;
				end
				default: begin
					psw_q <= psw_q;
				end
			endcase
		end
	end

	// ==========================================================
	// Non-maskable pending: any number of events collapse to one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_pend_q <= 1'b0;
		end else if (nmi_event) begin
			nmi_pend_q <= 1'b1;
		end else if (take_nmi) begin
			nmi_pend_q <= 1'b0;
		end
	end

	// Non-maskable handler tracking, with breaks nested inside it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_active_q <= 1'b0;
			brk_depth_q <= '0;
		end else if (take_nmi) begin
			nmi_active_q <= 1'b1;
			brk_depth_q <= '0;
		end else if (take_soft && nmi_active_q) begin
			brk_depth_q <= brk_depth_q + 1'b1;
		end else if (boundary && nmi_active_q) begin
			if (seq_i.kind == ianl_pkg::INS_RETURN_FROM_INTERRUPT_INSTR && brk_depth_q == '0) begin
				nmi_active_q <= 1'b0;
			end else if (seq_i.kind == ianl_pkg::INS_RETURN_FROM_BREAK_INSTR && brk_depth_q != '0) begin
				brk_depth_q <= brk_depth_q - 1'b1;
			end
		end
	end

	// ==========================================================
	// Deferral counter: instruction boundaries still to pass
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			defer_q <= 2'h0;
		end else if (wr_req || wr_mask || wr_prio || wr_psw) begin
			defer_q <= ianl_pkg::DEFER_REG;
		end else if (boundary && hold_ins) begin
			defer_q <= ianl_pkg::DEFER_INS;
		end else if (boundary && defer_q != 2'h0) begin
			defer_q <= defer_q - 2'h1;
		end
	end

	// ==========================================================
	// Entry sequence: save, vector, stall length
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_cnt_q <= 4'h0;
		end else if (take_mask && win_lvl) begin
			stall_cnt_q <= ianl_pkg::ENTRY_LO;
		end else if (take_any) begin
			stall_cnt_q <= ianl_pkg::ENTRY_HI;
		end else if (stall_cnt_q != 4'h0) begin
			stall_cnt_q <= stall_cnt_q - 4'h1;
		end
	end

	// Acceptance pulse toward the sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_q <= '0;
		end else begin
			ack_q.take <= take_any;
			ack_q.stall <= take_any || (stall_cnt_q != 4'h0); // Holds through the last count
			if (take_any) begin
				ack_q.psw_save <= psw_q;
				ack_q.idx <= take_mask ? win_idx : '0;
				if (take_soft) begin
					ack_q.src <= ianl_pkg::SRC_SOFT;
					ack_q.vector <= ianl_pkg::VEC_SOFT;
				end else if (take_nmi) begin
					ack_q.src <= ianl_pkg::SRC_NMI;
					ack_q.vector <= ianl_pkg::VEC_NMI;
				end else begin
					ack_q.src <= ianl_pkg::SRC_MASK;
					ack_q.vector <= ianl_pkg::VEC_BASE
						+ {10'h000, win_idx, 1'b0};
				end
			end
		end
	end

	// ==========================================================
	// APB read data and ready, answered in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (apb_setup) begin
			pready_q <= 1'b1;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
			if (paddr == ianl_pkg::OFS_REQ) begin
				prdata_q <= {14'h0000, req_q};
			end else if (paddr == ianl_pkg::OFS_MASK) begin
				prdata_q <= {14'h0000, mask_q};
			end else if (paddr == ianl_pkg::OFS_PRIO) begin
				prdata_q <= {14'h0000, prio_q};
			end else if (paddr == ianl_pkg::OFS_PSW) begin
				prdata_q <= {24'h000000, psw_q};
			end else if (paddr == ianl_pkg::OFS_STAT) begin
				prdata_q <= {20'h00000, stall_cnt_q, brk_depth_q,
					defer_q, nmi_pend_q, nmi_active_q};
			end else begin
				pslverr_q <= 1'b1;
			end
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign ack_o = ack_q;
	assign psw_o = psw_q;

endmodule : ianl_core

`default_nettype wire

// File: bench/ianl_chk.sv
// Assertion checker for the interrupt acknowledge and nesting logic
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Checker
module ianl_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Sequencer side
	input wire ianl_pkg::ianl_seq_type seq_i,
	input wire ianl_pkg::ianl_ack_type ack_o,
	input wire logic [7:0] psw_o,
	// Sources
	input wire logic [ianl_pkg::NSRC-1:0] src_event,
	input wire logic nmi_event
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_take_enable_clr: assert property (ack_o.take |-> !psw_o[7])
		else $error("enable flag still set on entry");
	chk_nmi_entry: assert property (ack_o.take && ack_o.src == ianl_pkg::SRC_NMI
		|-> psw_o[7] == 1'b0 && psw_o[1] == 1'b0 && ack_o.vector == ianl_pkg::VEC_NMI)
		else $error("non-maskable entry wrong");
	chk_soft_vec: assert property (ack_o.take && ack_o.src == ianl_pkg::SRC_SOFT
		|-> ack_o.vector == ianl_pkg::VEC_SOFT)
		else $error("break vector wrong");
	chk_mask_vec: assert property (ack_o.take && ack_o.src == ianl_pkg::SRC_MASK
		|-> ack_o.vector == ianl_pkg::VEC_BASE + 16'({ack_o.idx, 1'b0}))
		else $error("maskable vector wrong");
	chk_mask_enable: assert property (ack_o.take && ack_o.src == ianl_pkg::SRC_MASK
		|-> $past(psw_o[7]))
		else $error("maskable taken while disabled");
	chk_isp_level: assert property (ack_o.take && ack_o.src == ianl_pkg::SRC_MASK
		&& !$past(psw_o[1]) |-> !psw_o[1])
		else $error("low level taken in high handler");
	chk_stall_hi: assert property (ack_o.take
		&& !(ack_o.src == ianl_pkg::SRC_MASK && psw_o[1]) |-> ack_o.stall[*7] ##1 !ack_o.stall)
		else $error("entry length wrong");
	chk_stall_lo: assert property (ack_o.take
		&& ack_o.src == ianl_pkg::SRC_MASK && psw_o[1] |-> ack_o.stall[*8] ##1 !ack_o.stall)
		else $error("low level entry length wrong");
	chk_hold_defer: assert property (seq_i.done && !ack_o.stall
		&& seq_i.kind != ianl_pkg::INS_PLAIN && seq_i.kind != ianl_pkg::INS_BRK |=> !ack_o.take)
		else $error("acceptance after hold instruction");
endmodule : ianl_chk

bind ianl_core ianl_chk i_ianl_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .seq_i(seq_i), .ack_o(ack_o), .psw_o(psw_o),
	.src_event(src_event), .nmi_event(nmi_event));

`default_nettype wire

// File: bench/ianl_seq_model.sv
// Instruction sequencer model that completes instructions and keeps the stack
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Sequencer model
module ianl_seq_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Acknowledge
	input wire ianl_pkg::ianl_ack_type ack_o,
	// Completion
	output var ianl_pkg::ianl_seq_type seq_i
);
	ianl_pkg::ianl_instr_type prog[$];
	logic [7:0] stack[$];
	logic [1:0] gap_q;
	ianl_pkg::ianl_instr_type k;
	logic [7:0] p;

	// One completion every third cycle, none during entry stall
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_i <= '0;
			gap_q <= 2'h0;
		end else begin
			if (ack_o.take)
				stack.push_back(ack_o.psw_save);
			if (ack_o.stall || gap_q != 2'h2) begin
				seq_i <= '{1'b0, ianl_pkg::ianl_instr_type'(~seq_i.kind), ~seq_i.processor_status_word};
				if (!ack_o.stall)
					gap_q <= gap_q + 2'h1;
			end else begin
				k = (prog.size() != 0) ? prog.pop_front() : ianl_pkg::INS_PLAIN;
				p = ~seq_i.processor_status_word;
				if ((k == ianl_pkg::INS_RETURN_FROM_INTERRUPT_INSTR || k == ianl_pkg::INS_RETURN_FROM_BREAK_INSTR
					|| k == ianl_pkg::INS_PSW_LOAD) && stack.size() != 0)
					p = stack.pop_back();
				seq_i <= '{1'b1, k, p};
				gap_q <= 2'h0;
			end
		end
	end
endmodule : ianl_seq_model

`default_nettype wire

// File: bench/tb_interrupt_acknowledge_nesting_logic.sv
// Self-checking testbench of the interrupt acknowledge and nesting logic
`timescale 1ns/1ps
`default_nettype none

module tb_interrupt_acknowledge_nesting_logic;
	// ==========================================================
	// Signals
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, pv;
	logic pready, pslverr, er, got;
	ianl_pkg::ianl_seq_type seq_i;
	ianl_pkg::ianl_ack_type ack_o, tk;
	logic [7:0] psw_o, ps;
	logic [17:0] src_event = 18'h0;
	logic nmi_event = 1'b0;
	logic [31:0] rnd = 32'hffcab357;
	logic [31:0] rst_v[5] = '{32'h0, 32'h3ffff, 32'h3ffff, 32'h2, 32'h0};
	int miscompares = 0, checked = 0, cyc = 0, a, b, w;

	ianl_core i_ianl_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .seq_i(seq_i), .ack_o(ack_o), .psw_o(psw_o),
		.src_event(src_event), .nmi_event(nmi_event));
	ianl_seq_model i_ianl_seq_model (.pclk(pclk), .presetn(presetn), .ack_o(ack_o),
		.seq_i(seq_i));

	// Clock and hang limit
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			close_out();
		end
	end

	// ==========================================================
	// Helpers
	task automatic close_out;
		if (miscompares == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	function automatic logic [15:0] vec_of(input int i);
		return ianl_pkg::VEC_BASE + 16'(2 * i);
	endfunction : vec_of

	// Higher level first, then lowest index
	function automatic int pick(input logic [17:0] req, input logic [17:0] pri);
		for (int l = 0; l < 2; l++)
			for (int i = 0; i < 18; i++)
				if (req[i] && pri[i] == l[0])
					return i;
		return 0;
	endfunction : pick

	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic ev(input logic [17:0] m, input logic n);
		@(posedge pclk);
		src_event <= m;
		nmi_event <= n;
		@(posedge pclk);
		src_event <= 18'h0;
		nmi_event <= 1'b0;
	endtask : ev

	task automatic ins(input ianl_pkg::ianl_instr_type k);
		i_ianl_seq_model.prog.push_back(k);
		while (i_ianl_seq_model.prog.size() != 0)
			@(posedge pclk);
	endtask : ins

	task automatic wt(input int n);
		got = 1'b0;
		for (int i = 0; i < n && !got; i++) begin
			@(posedge pclk);
			if (ack_o.take === 1'b1) begin
				got = 1'b1;
				tk = ack_o;
				ps = psw_o;
			end
		end
	endtask : wt

	task automatic want(input logic [1:0] s, input logic [15:0] v);
		wt(80);
		check("take", got, 1'b1);
		check("source", tk.src, s);
		check("vector", tk.vector, v);
	endtask : want

	// ==========================================================
	// Sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("status word", psw_o, 32'h2);
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 12'(4 * i), 32'h0);
			check("reset value", rd, rst_v[i]);
		end
		apb(1'b0, 12'h020, 32'h0);
		check("unmapped error", er, 1'b1);
		// Non-maskable with enable clear, then repeats inside its handler
		ev(18'h0, 1'b1);
		want(ianl_pkg::SRC_NMI, ianl_pkg::VEC_NMI);
		check("entry status", ps, 32'h0);
		check("saved status", tk.psw_save, 32'h2);
		ins(ianl_pkg::INS_EI);
		a = int'(rnd[7:0]) % 18;
		apb(1'b1, ianl_pkg::OFS_MASK, ~(32'h1 << a));
		ev(18'h1 << a, 1'b1);
		ev(18'h0, 1'b1);
		wt(80);
		check("nested in nmi", got, 1'b0);
		ins(ianl_pkg::INS_RETURN_FROM_INTERRUPT_INSTR);
		want(ianl_pkg::SRC_NMI, ianl_pkg::VEC_NMI);
		ins(ianl_pkg::INS_RETURN_FROM_INTERRUPT_INSTR);
		wt(80);
		check("extra take", got, 1'b0);
		ins(ianl_pkg::INS_EI);
		want(ianl_pkg::SRC_MASK, vec_of(a));
		check("index", tk.idx, a);
		check("saved status", tk.psw_save, 32'h82);
		check("level copy", ps[1], 1'b1);
		apb(1'b0, ianl_pkg::OFS_REQ, 32'h0);
		check("request cleared", rd, 32'h0);
		ins(ianl_pkg::INS_RETURN_FROM_INTERRUPT_INSTR);
		repeat (2) @(posedge pclk);
		check("restored status", psw_o, 32'h82);
		// Random pairs: one wins, the other follows the return
		for (int n = 0; n < 4; n++) begin
			rnd = lfsr(rnd);
			a = int'(rnd[7:0]) % 9;
			b = a + 1 + int'(rnd[15:8]) % 9;
			pv = ~((32'h1 << a) | (32'h1 << b));
			apb(1'b1, ianl_pkg::OFS_MASK, pv);
			pv = pv | (rnd[16] << a) | (rnd[17] << b);
			apb(1'b1, ianl_pkg::OFS_PRIO, pv);
			ev((18'h1 << a) | (18'h1 << b), 1'b0);
			w = pick((18'h1 << a) | (18'h1 << b), pv[17:0]);
			want(ianl_pkg::SRC_MASK, vec_of(w));
			check("level copy", ps[1], pv[w]);
			ins(ianl_pkg::INS_RETURN_FROM_INTERRUPT_INSTR);
			want(ianl_pkg::SRC_MASK, vec_of(a + b - w));
			ins(ianl_pkg::INS_RETURN_FROM_INTERRUPT_INSTR);
		end
		// High level handler: low level waits, high level nests
		apb(1'b1, ianl_pkg::OFS_PRIO, ~(32'h1 << a));
		ev(18'h1 << a, 1'b0);
		want(ianl_pkg::SRC_MASK, vec_of(a));
		ins(ianl_pkg::INS_EI);
		ev(18'h1 << b, 1'b0);
		wt(80);
		check("low level nested", got, 1'b0);
		ev(18'h1 << a, 1'b0);
		want(ianl_pkg::SRC_MASK, vec_of(a));
		ins(ianl_pkg::INS_RETURN_FROM_INTERRUPT_INSTR);
		ins(ianl_pkg::INS_RETURN_FROM_INTERRUPT_INSTR);
		want(ianl_pkg::SRC_MASK, vec_of(b));
		ins(ianl_pkg::INS_RETURN_FROM_INTERRUPT_INSTR);
		// Break with enable clear
		ins(ianl_pkg::INS_DI);
		ins(ianl_pkg::INS_BRK);
		want(ianl_pkg::SRC_SOFT, ianl_pkg::VEC_SOFT);
		check("saved status", tk.psw_save, 32'h2);
		ins(ianl_pkg::INS_RETURN_FROM_BREAK_INSTR);
		repeat (2) @(posedge pclk);
		check("restored status", psw_o, 32'h2);
		// Status word written over the bus, then popped, then a hold instruction
		apb(1'b1, ianl_pkg::OFS_PSW, 32'h82);
		apb(1'b0, ianl_pkg::OFS_PSW, 32'h0);
		check("bus status word", rd, 32'h82);
		i_ianl_seq_model.stack.push_back(8'h80);
		ins(ianl_pkg::INS_PSW_LOAD);
		ins(ianl_pkg::INS_HOLD);
		check("popped status", psw_o, 32'h80);
		close_out();
	end
endmodule : tb_interrupt_acknowledge_nesting_logic

`default_nettype wire
